/* File: src/psb_pkg.sv */
// Purpose: Shared constants of the sideband pin block: register map,
//          field positions, reset values and timing counts.
// Assumes: 10 MHz system clock, which is also the RMII reference clock.
// Notes:   Byte addresses are word aligned on a 32-bit AXI4-Lite bus.
package psb_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam int ACT_HOLD_MS = 50;
    localparam int STRAP_SETTLE = 3;

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STRAP = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;

    localparam int CTRL_IRQ_POL = 0;
    localparam int CTRL_ACTIVITY_LED_OUT_LSB = 2;
    localparam int CTRL_SPEED_LED_OUT_LSB = 4;
    localparam int CTRL_W = 6;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    localparam int ST_MODE_LSB = 0;
    localparam int ST_TCHAIN_PIN = 3;
    localparam int ST_TEST_EN = 4;
    localparam int ST_XOVER = 5;
    localparam int ST_B2B = 6;
    localparam int ST_RSVD = 7;
    localparam int ST_VALID = 8;

    localparam int EV_LINK = 0;
    localparam int EV_RSVD = 1;
    localparam int EV_RX = 2;
    localparam int EV_TX = 3;
    localparam int EV_W = 4;
    localparam logic [3:0] MASK_RESET = 4'h0;

    localparam logic [2:0] MODE_NORMAL_NOX = 3'h1;
    localparam logic [2:0] MODE_B2B_X = 3'h5;
    localparam logic [2:0] MODE_NORMAL_X = 3'h7;

    localparam logic [1:0] LED_DEFAULT = 2'h0;
    localparam logic [1:0] LED_LINK = 2'h1;
    localparam logic [1:0] LED_ACT = 2'h2;
    localparam logic [1:0] LED_OFF = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : psb_pkg

/* File: src/psb_sync.sv */
// Purpose: Two-stage synchroniser for a group of pin levels.
// Assumes: Each bit is an independent level; no word coherence is kept.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none
module psb_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= async_i[gi];
                    sync_q <= meta_q;
                end
            end
            assign sync_o[gi] = sync_q;
        end
    endgenerate
endmodule : psb_sync
`default_nettype wire

/* File: src/psb_sideband.sv */
// Purpose: Strap latch, interrupt pin, LED drivers and RMII data
//          qualification of a PHY, with an AXI4-Lite register slave.
// Assumes: MAC and PHY core logic run on sys_clk_i; strap pins do not.
// Notes:   Shared pins stay undriven until the straps have been taken.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Both LEDs are active low, programmable; defaults link/activity and speed.
// - Transmit data counts as valid only while transmit enable is high.
// - Receive data pins carry data only while data valid is high.
// - Every strap pin is sampled at reset release and kept.
// - Mode bit 1 pin serves only as a strap, nothing else.
// - Interrupt pin polarity programmable, active low after reset.
// - Interrupt pin is sampled as test strap before it drives.
// - Mode codes 001, 101, 111 decode; all other codes reserved.
// - Test-chain strap low enables test mode; high is normal.
module psb_sideband
    import psb_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES,
    parameter int HOLD_MS = ACT_HOLD_MS
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // AXI4-Lite slave.
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Strap pins.
    input wire logic mode_strap_bit0_i,
    input wire logic mode_strap_bit1_i,
    input wire logic crs_dv_i,
    input wire logic irq_out_i,
    output logic irq_out_o,
    output logic irq_out_oe_o,
    // RMII toward the MAC.
    input wire logic tx_en_i,
    input wire logic [1:0] txd_i,
    output logic crs_dv_o,
    output logic crs_dv_oe_o,
    output logic [1:0] rxd_o,
    output logic rxd_oe_o,
    // Transceiver core side.
    output logic tx_valid_o,
    output logic [1:0] tx_data_o,
    input wire logic rx_valid_i,
    input wire logic [1:0] rx_data_i,
    input wire logic link_up_i,
    input wire logic speed_100_i,
    // Decoded configuration.
    output logic strap_valid_o,
    output logic [2:0] mode_code_o,
    output logic mode_reserved_o,
    output logic auto_xover_o,
    output logic back_to_back_o,
    output logic test_chain_en_o,
    // LEDs and interrupt.
    output logic activity_led_out_n_o,
    output logic speed_led_out_n_o,
    output logic irq_o
);
    generate
        if (TICK_CYC < 2 || HOLD_MS < 1 || HOLD_MS > 255) begin : g_chk
            $error("psb_sideband: unsupported timing parameters");
        end
    endgenerate

    typedef enum logic [1:0] {
        PSB_SETTLE,
        PSB_LATCH,
        PSB_RUN
    } psb_phase_t;

    psb_phase_t phase_q;
    logic [1:0] settle_q;
    logic [3:0] pins_sync;
    logic [2:0] mode_q;
    logic tchain_q;
    logic rsvd_pulse_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [EV_W-1:0] stat_q;
    logic [EV_W-1:0] mask_q;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    logic link_q;
    logic rx_prev_q;
    logic tx_prev_q;
    logic [31:0] tick_q;
    logic tick;
    logic [7:0] act_q;
    logic act;
    logic running;

    // Strap pins cross in from outside the clock domain.
    psb_sync #(
        .W(4)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .async_i({irq_out_i, crs_dv_i, mode_strap_bit1_i, mode_strap_bit0_i}),
        .sync_o(pins_sync)
    );

    // The reset value is a constant, so the pins are taken a few cycles
    // after release, once the synchroniser holds their real levels.
    // Sample after release.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_q <= PSB_SETTLE;
            settle_q <= 2'h0;
        end else begin
            unique case (phase_q)
                PSB_SETTLE: begin
                    settle_q <= settle_q + 2'h1;
                    if (settle_q == 2'(STRAP_SETTLE - 1)) begin
                        phase_q <= PSB_LATCH;
                    end
                end
                PSB_LATCH: begin
                    phase_q <= PSB_RUN;
                end
                PSB_RUN: begin
                    phase_q <= PSB_RUN;
                end
            endcase
        end
    end

    assign running = (phase_q == PSB_RUN);

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_q <= 3'h0;
            tchain_q <= 1'b1;
        end else if (phase_q == PSB_LATCH) begin
            mode_q <= pins_sync[2:0];
            tchain_q <= pins_sync[3];
        end
    end

    always_comb begin
        auto_xover_o = 1'b0;
        back_to_back_o = 1'b0;
        mode_reserved_o = 1'b0;
        unique case (mode_q)
            MODE_NORMAL_NOX: begin
                auto_xover_o = 1'b0;
            end
            MODE_B2B_X: begin
                auto_xover_o = 1'b1;
                back_to_back_o = 1'b1;
            end
            MODE_NORMAL_X: begin
                auto_xover_o = 1'b1;
            end
            default: begin
                mode_reserved_o = running;
            end
        endcase
    end

    assign mode_code_o = mode_q;
    assign strap_valid_o = running;
    assign test_chain_en_o = running & ~tchain_q;

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_valid_o <= 1'b0;
            tx_data_o <= 2'h0;
        end else begin
            tx_valid_o <= tx_en_i & running;
            tx_data_o <= (tx_en_i & running) ? txd_i : 2'h0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            crs_dv_o <= 1'b0;
            rxd_o <= 2'h0;
        end else begin
            crs_dv_o <= rx_valid_i & running;
            rxd_o <= (rx_valid_i & running) ? rx_data_i : 2'h0;
        end
    end

    // Shared pins must float while their straps are being read.
    assign crs_dv_oe_o = running;
    assign rxd_oe_o = running;

    // Interrupt events.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            link_q <= 1'b0;
            rx_prev_q <= 1'b0;
            tx_prev_q <= 1'b0;
            rsvd_pulse_q <= 1'b0;
        end else begin
            link_q <= link_up_i;
            rx_prev_q <= rx_valid_i;
            tx_prev_q <= tx_en_i;
            rsvd_pulse_q <= (phase_q == PSB_LATCH);
        end
    end

    always_comb begin
        ev = '0;
        ev[EV_LINK] = running & (link_up_i ^ link_q);
        ev[EV_RSVD] = rsvd_pulse_q & mode_reserved_o;
        ev[EV_RX] = running & rx_valid_i & ~rx_prev_q;
        ev[EV_TX] = running & tx_en_i & ~tx_prev_q;
    end

    // Millisecond enable for the activity stretch.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_q <= 32'h0;
        end else if (tick_q == 32'(TICK_CYC - 1)) begin
            tick_q <= 32'h0;
        end else begin
            tick_q <= tick_q + 32'h1;
        end
    end

    assign tick = (tick_q == 32'(TICK_CYC - 1));

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            act_q <= 8'h0;
        end else if (running && (rx_valid_i || tx_en_i)) begin
            act_q <= 8'(HOLD_MS);
        end else if (tick && act_q != 8'h0) begin
            act_q <= act_q - 8'h1;
        end
    end

    assign act = (act_q != 8'h0);

    function automatic logic led_on(input logic [1:0] func,
                                    input logic dflt,
                                    input logic link,
                                    input logic activity);
        logic on;
        on = 1'b0;
        unique case (func)
            LED_DEFAULT: on = dflt;
            LED_LINK: on = link;
            LED_ACT: on = activity;
            LED_OFF: on = 1'b0;
        endcase
        return on;
    endfunction : led_on

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            activity_led_out_n_o <= 1'b1;
            speed_led_out_n_o <= 1'b1;
        end else begin
            activity_led_out_n_o <= ~(running & led_on(
                ctrl_q[CTRL_ACTIVITY_LED_OUT_LSB +: 2], link_up_i & ~act,
                link_up_i, act));
            speed_led_out_n_o <= ~(running & led_on(
                ctrl_q[CTRL_SPEED_LED_OUT_LSB +: 2], link_up_i & speed_100_i,
                link_up_i, act));
        end
    end

    // AXI4-Lite write path: address and data may come in either order.
    logic aw_have_q;
    logic w_have_q;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write;

    assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
    assign do_write = aw_have_q & w_have_q;

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_q[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= CTRL_RESET;
            mask_q <= MASK_RESET;
        end else if (do_write && w_strb_q[0]) begin
            if (aw_addr_q == ADDR_CTRL) begin
                ctrl_q <= w_data_q[CTRL_W-1:0];
            end
            if (aw_addr_q == ADDR_IRQ_MASK) begin
                mask_q <= w_data_q[EV_W-1:0];
            end
        end
    end

    assign clr = (do_write && w_strb_q[0] && aw_addr_q == ADDR_IRQ_STAT) ?
                 w_data_q[EV_W-1:0] : '0;

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~clr) | ev;
        end
    end

    // AXI4-Lite read path.
    logic [31:0] rd_word;

    assign s_axi_arready = ~s_axi_rvalid;

    always_comb begin
        rd_word = 32'h0;
        unique case (s_axi_araddr)
            ADDR_CTRL: rd_word[CTRL_W-1:0] = ctrl_q;
            ADDR_STRAP: begin
                rd_word[ST_MODE_LSB +: 3] = mode_q;
                rd_word[ST_TCHAIN_PIN] = tchain_q;
                rd_word[ST_TEST_EN] = test_chain_en_o;
                rd_word[ST_XOVER] = auto_xover_o;
                rd_word[ST_B2B] = back_to_back_o;
                rd_word[ST_RSVD] = mode_reserved_o;
                rd_word[ST_VALID] = running;
            end
            ADDR_IRQ_STAT: rd_word[EV_W-1:0] = stat_q;
            ADDR_IRQ_MASK: rd_word[EV_W-1:0] = mask_q;
            default: rd_word = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (s_axi_araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Interrupt level and pin.
    assign irq_o = |(stat_q & mask_q);

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_out_o <= 1'b1;
            irq_out_oe_o <= 1'b0;
        end else begin
            irq_out_o <= ctrl_q[CTRL_IRQ_POL] ? irq_o : ~irq_o;
            irq_out_oe_o <= running;
        end
    end
endmodule : psb_sideband
`default_nettype wire

/* File: sim/psb_mac_model.sv */
// Purpose: Behavioural MAC on the RMII side of the sideband block.
// Assumes: A frame starts on a one-cycle start pulse; no reset needed.
// Notes:   Idle transmit data toggles, so stale bits never look valid.
`timescale 1ns/100ps
`default_nettype none
module psb_mac_model (
    input wire logic sys_clk_i,
    input wire logic start_i,
    input wire logic [7:0] len_i,
    output logic tx_en_o,
    output logic [1:0] txd_o,
    input wire logic crs_dv_i,
    input wire logic [1:0] rxd_i,
    output logic [7:0] rx_cnt_o,
    output logic [7:0] rx_sum_o
);
    logic [7:0] left_q = 8'h00;
    logic [1:0] last_q = 2'h0;
    logic [7:0] cnt_q = 8'h00;
    logic [7:0] sum_q = 8'h00;

    assign tx_en_o = left_q != 8'h00;
    assign txd_o = tx_en_o ? left_q[1:0] : ~last_q;
    assign rx_cnt_o = cnt_q;
    assign rx_sum_o = sum_q;

    always @(posedge sys_clk_i) begin
        last_q <= txd_o;
        if (start_i) begin
            left_q <= len_i;
        end else if (tx_en_o) begin
            left_q <= left_q - 8'h01;
        end
        if (crs_dv_i === 1'b1) begin
            cnt_q <= cnt_q + 8'h01;
            sum_q <= sum_q + {6'h00, rxd_i};
        end
    end
endmodule : psb_mac_model
`default_nettype wire

/* File: sim/psb_sideband_chk.sv */
// Purpose: Port-level assertions of the sideband pin block.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes:   Attached by bind to every instance of the block.
`timescale 1ns/100ps
`default_nettype none
module psb_sideband_chk (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic tx_en_i,
    input wire logic [1:0] txd_i,
    input wire logic tx_valid_o,
    input wire logic [1:0] tx_data_o,
    input wire logic rx_valid_i,
    input wire logic [1:0] rx_data_i,
    input wire logic crs_dv_o,
    input wire logic [1:0] rxd_o,
    input wire logic crs_dv_oe_o,
    input wire logic irq_out_oe_o,
    input wire logic irq_out_i,
    input wire logic crs_dv_i,
    input wire logic mode_strap_bit0_i,
    input wire logic mode_strap_bit1_i,
    input wire logic strap_valid_o,
    input wire logic [2:0] mode_code_o,
    input wire logic mode_reserved_o,
    input wire logic auto_xover_o,
    input wire logic back_to_back_o,
    input wire logic test_chain_en_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_tx_data;
        strap_valid_o && $past(strap_valid_o) |->
            tx_valid_o == $past(tx_en_i) &&
            tx_data_o == ($past(tx_en_i) ? $past(txd_i) : 2'h0);
    endproperty
    a_tx_data: assert property (p_tx_data)
        else $error("tx copy wrong");

    property p_rx_data;
        strap_valid_o && $past(strap_valid_o) |->
            crs_dv_o == $past(rx_valid_i) &&
            rxd_o == ($past(rx_valid_i) ? $past(rx_data_i) : 2'h0);
    endproperty
    a_rx_data: assert property (p_rx_data)
        else $error("rx copy wrong");

    property p_rx_idle;
        !crs_dv_o |-> rxd_o == 2'h0;
    endproperty
    a_rx_idle: assert property (p_rx_idle)
        else $error("rx data while idle");

    property p_strap_take;
        $rose(strap_valid_o) |-> mode_code_o == {$past(crs_dv_i, 2),
            $past(mode_strap_bit1_i, 2), $past(mode_strap_bit0_i, 2)};
    endproperty
    a_strap_take: assert property (p_strap_take)
        else $error("mode strap wrong");

    property p_test_take;
        $rose(strap_valid_o) |-> test_chain_en_o == !$past(irq_out_i, 2);
    endproperty
    a_test_take: assert property (p_test_take)
        else $error("test strap wrong");

    property p_strap_hold;
        strap_valid_o && $past(strap_valid_o) |->
            $stable(mode_code_o) && $stable(test_chain_en_o);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("strap changed");

    property p_decode;
        strap_valid_o |->
            mode_reserved_o == !(mode_code_o inside {3'h1, 3'h5, 3'h7}) &&
            back_to_back_o == (mode_code_o == 3'h5) &&
            auto_xover_o == (mode_code_o[2] && mode_code_o[0]);
    endproperty
    a_decode: assert property (p_decode)
        else $error("mode decode wrong");

    property p_pin_wait;
        !strap_valid_o |-> !crs_dv_oe_o && !irq_out_oe_o;
    endproperty
    a_pin_wait: assert property (p_pin_wait)
        else $error("pin driven early");

    property p_irq_late;
        $rose(strap_valid_o) |-> !irq_out_oe_o ##1 irq_out_oe_o;
    endproperty
    a_irq_late: assert property (p_irq_late)
        else $error("irq enable late");
endmodule : psb_sideband_chk

bind psb_sideband psb_sideband_chk i_psb_sideband_chk (.*);
`default_nettype wire

/* File: sim/psb_sideband_tb_top.sv */
// Purpose: Self-checking bench of the sideband pin block.
// Assumes: Bus tasks are entered just after a rising clock edge.
// Notes:   Short tick and hold counts keep the LED timing brief.
`timescale 1ns/100ps
`default_nettype none
module psb_sideband_tb_top
    import psb_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic arst_n_i, mac_go, rsvd;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, exp_st;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic mode_strap_bit0_i, mode_strap_bit1_i, strap_c2, strap_tp;
    logic crs_pin, irq_pin, irq_out_o, irq_out_oe_o, crs_dv_o, crs_dv_oe_o;
    logic tx_en_i, tx_valid_o, rx_valid_i, link_up_i, speed_100_i;
    logic strap_valid_o, mode_reserved_o, auto_xover_o, back_to_back_o;
    logic test_chain_en_o, activity_led_out_n_o, speed_led_out_n_o, irq_o;
    logic [1:0] txd_i, rxd_o, tx_data_o, rx_data_i;
    logic [2:0] mode_code_o;
    logic [7:0] rx_cnt, rx_sum;
    int num_errors = 0;
    int tests_run = 0;
    int tx_cnt = 0;
    int tx_sum = 0;
    int exp_sum = 0;

    always #50 sys_clk_i = ~sys_clk_i;
    // Released pins fall back to the strap resistor level.
    assign crs_pin = crs_dv_oe_o ? crs_dv_o : strap_c2;
    assign irq_pin = irq_out_oe_o ? irq_out_o : strap_tp;

    psb_sideband #(.TICK_CYC(4), .HOLD_MS(2)) i_psb_sideband (
        .sys_clk_i, .arst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .mode_strap_bit0_i, .mode_strap_bit1_i,
        .crs_dv_i(crs_pin), .irq_out_i(irq_pin), .irq_out_o, .irq_out_oe_o,
        .tx_en_i, .txd_i, .crs_dv_o, .crs_dv_oe_o, .rxd_o, .rxd_oe_o(),
        .tx_valid_o, .tx_data_o, .rx_valid_i, .rx_data_i, .link_up_i,
        .speed_100_i, .strap_valid_o, .mode_code_o, .mode_reserved_o,
        .auto_xover_o, .back_to_back_o, .test_chain_en_o,
        .activity_led_out_n_o, .speed_led_out_n_o, .irq_o
    );

    psb_mac_model i_psb_mac_model (
        .sys_clk_i, .start_i(mac_go), .len_i(8'h0a), .tx_en_o(tx_en_i),
        .txd_o(txd_i), .crs_dv_i(crs_dv_o), .rxd_i(rxd_o),
        .rx_cnt_o(rx_cnt), .rx_sum_o(rx_sum)
    );

    always @(posedge sys_clk_i) begin
        if (tx_valid_o === 1'b1) begin
            tx_cnt <= tx_cnt + 1;
            tx_sum <= tx_sum + tx_data_o;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    task automatic hang(input int n);
        if (n >= 50) begin
            num_errors++;
            test_done();
        end
    endtask : hang

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] v,
                          output logic [1:0] resp);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n == 0 || s_axi_awvalid || s_axi_wvalid; n++) begin
            hang(n);
            @(posedge sys_clk_i);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        for (n = 0; s_axi_bvalid !== 1'b1; n++) begin
            hang(n);
            @(posedge sys_clk_i);
        end
        resp = s_axi_bresp;
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] v,
                          output logic [1:0] resp);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n == 0 || s_axi_arvalid; n++) begin
            hang(n);
            @(posedge sys_clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        for (n = 0; s_axi_rvalid !== 1'b1; n++) begin
            hang(n);
            @(posedge sys_clk_i);
        end
        v = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : axi_rd

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        axi_rd(a, d, r);
        chk(d, exp);
    endtask : rd_chk

    task automatic do_strap(input logic [2:0] c, input logic tp);
        arst_n_i <= 1'b0;
        {strap_c2, mode_strap_bit1_i, mode_strap_bit0_i} <= c;
        strap_tp <= tp;
        tick(3);
        arst_n_i <= 1'b1;
        tick(8);
    endtask : do_strap

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, mac_go} = 4'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        {rx_valid_i, rx_data_i, link_up_i, speed_100_i} = 5'h0;
        do_strap(3'h7, 1'b1);
        rd_chk(ADDR_CTRL, {26'h0, CTRL_RESET});
        rd_chk(ADDR_IRQ_MASK, {28'h0, MASK_RESET});
        chk(irq_out_o, 1'b1);
        chk({activity_led_out_n_o, speed_led_out_n_o}, 2'h3);
        $display("test defaults done");
        for (int c = 0; c < 8; c++) begin
            do_strap(c[2:0], c[1]);
            rsvd = !(c inside {1, 5, 7});
            exp_st = {23'h0, 1'b1, rsvd, c == 5, c == 5 || c == 7,
                      !c[1], c[1], c[2:0]};
            chk(mode_code_o, c[2:0]);
            chk(test_chain_en_o, !c[1]);
            rd_chk(ADDR_STRAP, exp_st);
        end
        $display("test straps done");
        // Mode strap pins wiggle after the latch; the mode must not follow.
        for (int k = 0; k < 6; k++) begin
            {mode_strap_bit1_i, mode_strap_bit0_i} <= k[1:0];
            tick(1);
        end
        chk(mode_code_o, 3'h7);
        axi_wr(ADDR_STRAP, 32'h0, r);
        rd_chk(ADDR_STRAP, 32'h12f);
        $display("test hold done");
        axi_wr(ADDR_IRQ_STAT, 32'hf, r);
        mac_go <= 1'b1;
        tick(1);
        mac_go <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            rx_valid_i <= 1'b1;
            rx_data_i <= k[1:0];
            tick(1);
        end
        rx_valid_i <= 1'b0;
        rx_data_i <= 2'h3;
        tick(12);
        for (int k = 1; k <= 10; k++) exp_sum += k % 4;
        chk(tx_cnt, 10);
        chk(tx_sum, exp_sum);
        chk({rx_cnt, rx_sum}, 16'h0607);
        $display("test rmii done");
        rd_chk(ADDR_IRQ_STAT, 32'hc);
        chk(irq_o, 1'b0);
        axi_wr(ADDR_IRQ_MASK, 32'h8, r);
        tick(2);
        chk({irq_o, irq_out_o}, 2'h2);
        axi_wr(ADDR_CTRL, 32'h1, r);
        tick(2);
        chk(irq_out_o, 1'b1);
        axi_wr(ADDR_IRQ_STAT, 32'h8, r);
        tick(2);
        chk({irq_o, irq_out_o}, 2'h0);
        link_up_i <= 1'b1;
        tick(3);
        rd_chk(ADDR_IRQ_STAT, 32'h5);
        $display("test interrupt done");
        axi_wr(ADDR_CTRL, {26'h0, LED_OFF, LED_LINK, 2'h0}, r);
        tick(3);
        chk({activity_led_out_n_o, speed_led_out_n_o}, 2'h1);
        axi_wr(ADDR_CTRL, 32'h0, r);
        speed_100_i <= 1'b1;
        tick(20);
        chk({activity_led_out_n_o, speed_led_out_n_o}, 2'h0);
        axi_wr(4'h2, 32'h1, r);
        chk(r, RESP_SLVERR);
        axi_rd(4'h1, d, r);
        chk(r, RESP_SLVERR);
        rd_chk(ADDR_CTRL, 32'h0);
        $display("test leds and bus done");
        test_done();
    end
endmodule : psb_sideband_tb_top
`default_nettype wire
